// ==== logic/dcd_clock_doubler.sv ====
// Dual oscillator source selection, clock doubler and instruction divider
// Behaviour
// - core tick on every selected oscillator edge, except old source edges while a handover is pending
// - instruction tick every ten core ticks
// - primary oscillator is high speed, 10 MHz max
// - secondary oscillator is 32.768 kHz low speed
// - source switch only through handshake sequence
// - idle oscillator may be disabled by software
// - unused low speed pins become general ports
`timescale 1ns/1ps
`include "dcd_defines.svh"

module dcd_clock_doubler #(
    parameter int unsigned CORE_PER_INSTR = `DCD_CORE_PER_INSTR,
    parameter int unsigned HS_MIN_HALF    = `DCD_HS_MIN_HALF_CYC
) (
    // Clock and reset
    input  wire logic               mclk,
    input  wire logic               rst_n,
    // Oscillator inputs from pins
    input  wire logic               hs_osc_pin,
    input  wire dcd_pkg::dcd_pin_type ls_pin0,
    output dcd_pkg::dcd_pin_type    ls_pin0_drv,
    input  wire dcd_pkg::dcd_pin_type ls_pin1,
    output dcd_pkg::dcd_pin_type    ls_pin1_drv,
    // Software control
    input  wire logic               sel_low_req,
    input  wire logic               hs_enable_req,
    input  wire logic               ls_enable_req,
    // General port use of the low speed pins
    input  wire logic [1:0]         gpio_out,
    input  wire logic [1:0]         gpio_oe,
    output logic [1:0]              gpio_in,
    // Clock outputs and status
    output logic                    hs_osc_on,
    output logic                    ls_osc_on,
    output logic                    selected_oscillator_input,
    output logic                    core_tick,
    output logic                    instr_tick,
    output logic                    sel_low,
    output logic                    switch_busy,
    output logic                    hs_overspeed
);

    localparam int unsigned DW = $clog2(CORE_PER_INSTR);
    localparam int unsigned HW = $clog2(HS_MIN_HALF + 1);

    // Pin synchronisers, first stage read only by second stage
    logic [2:0]  sync1_q;
    logic [2:0]  sync1_d;
    logic [2:0]  sync2_q;
    logic [2:0]  sync2_d;
    logic [2:0]  prev_q;
    logic [2:0]  prev_d;

    dcd_pkg::dcd_state_type state_q;
    dcd_pkg::dcd_state_type state_d;
    logic [DW-1:0] div_q;
    logic [DW-1:0] div_d;
    logic [HW-1:0] hs_gap_q;
    logic [HW-1:0] hs_gap_d;
    logic          core_q;
    logic          core_d;
    logic          instr_q;
    logic          instr_d;
    logic          ovr_q;
    logic          ovr_d;
    logic          osc_q;
    logic          osc_d;
    logic [1:0]    gpio_in_q;
    logic [1:0]    gpio_in_d;

    logic hs_edge;
    logic ls_edge;
    logic run_low;
    logic hs_on;
    logic ls_on;

    assign hs_edge = sync2_q[0] ^ prev_q[0];
    assign ls_edge = sync2_q[1] ^ prev_q[1];
    assign run_low = (state_q == dcd_pkg::DCD_RUN_LOW) || (state_q == dcd_pkg::DCD_WAIT_HIGH);

    // selected or switching target stays powered
    assign hs_on = hs_enable_req || !run_low || (state_q == dcd_pkg::DCD_WAIT_HIGH);
    assign ls_on = ls_enable_req || run_low || (state_q == dcd_pkg::DCD_WAIT_LOW);

    always_comb begin
        sync1_d = {ls_pin1.in, ls_pin0.in, hs_osc_pin};
        sync2_d = sync1_q;
        prev_d  = sync2_q;
    end

    // Source selection sequence
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            dcd_pkg::DCD_RUN_HIGH: begin
                if (sel_low_req && ls_enable_req) begin
                    state_d = dcd_pkg::DCD_WAIT_LOW;
                end
            end
            dcd_pkg::DCD_WAIT_LOW: begin
                // hand over on a target edge
                if (!sel_low_req || !ls_enable_req) begin
                    state_d = dcd_pkg::DCD_RUN_HIGH;
                end else if (ls_edge) begin
                    state_d = dcd_pkg::DCD_RUN_LOW;
                end
            end
            dcd_pkg::DCD_RUN_LOW: begin
                if (!sel_low_req && hs_enable_req) begin
                    state_d = dcd_pkg::DCD_WAIT_HIGH;
                end
            end
            dcd_pkg::DCD_WAIT_HIGH: begin
                // hand over on a target edge
                if (sel_low_req || !hs_enable_req) begin
                    state_d = dcd_pkg::DCD_RUN_LOW;
                end else if (hs_edge) begin
                    state_d = dcd_pkg::DCD_RUN_HIGH;
                end
            end
        endcase
    end

    // Doubler and divider
    always_comb begin
        // one core tick per edge, twice oscillator rate
        core_d  = run_low ? ls_edge : hs_edge;
        osc_d   = run_low ? sync2_q[1] : sync2_q[0];
        // waiting target edge cannot clip a tick
        if (state_q == dcd_pkg::DCD_WAIT_LOW && ls_edge) begin
            core_d = 1'b1;
            osc_d  = sync2_q[1];
        end else if (state_q == dcd_pkg::DCD_WAIT_HIGH && hs_edge) begin
            core_d = 1'b1;
            osc_d  = sync2_q[0];
        end else if (state_q == dcd_pkg::DCD_WAIT_LOW || state_q == dcd_pkg::DCD_WAIT_HIGH) begin
            // Old source edges give no core tick while the handover is pending
            core_d = 1'b0;
        end
        div_d   = div_q;
        instr_d = 1'b0;
        if (core_d) begin
            if (div_q == DW'(CORE_PER_INSTR - 1)) begin
                div_d   = '0;
                instr_d = 1'b1;
            end else begin
                div_d = div_q + DW'(1);
            end
        end
    end

    // High speed edge spacing check
    always_comb begin
        hs_gap_d = hs_gap_q;
        ovr_d    = ovr_q;
        if (hs_edge) begin
            // edges closer than 10 MHz half period
            if (hs_gap_q < HW'(HS_MIN_HALF) && !run_low) begin
                ovr_d = 1'b1;
            end
            hs_gap_d = '0;
        end else if (hs_gap_q != HW'(HS_MIN_HALF)) begin
            hs_gap_d = hs_gap_q + HW'(1);
        end
    end

    // pins go to port use when low oscillator idle
    always_comb begin
        gpio_in_d = sync2_q[2:1];
        if (ls_on) begin
            gpio_in_d = 2'h0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q   <= 3'h0;
            sync2_q   <= 3'h0;
            prev_q    <= 3'h0;
            state_q   <= dcd_pkg::DCD_RUN_HIGH;
            div_q     <= '0;
            // Start saturated so the first edge after reset is not taken as overspeed
            hs_gap_q  <= HW'(HS_MIN_HALF);
            core_q    <= 1'b0;
            instr_q   <= 1'b0;
            ovr_q     <= 1'b0;
            osc_q     <= 1'b0;
            gpio_in_q <= 2'h0;
        end else begin
            sync1_q   <= sync1_d;
            sync2_q   <= sync2_d;
            prev_q    <= prev_d;
            state_q   <= state_d;
            div_q     <= div_d;
            hs_gap_q  <= hs_gap_d;
            core_q    <= core_d;
            instr_q   <= instr_d;
            ovr_q     <= ovr_d;
            osc_q     <= osc_d;
            gpio_in_q <= gpio_in_d;
        end
    end

    // low speed crystal on pin 0, pin 1 undriven in oscillator use
    // port drive only while the low oscillator is off
    always_comb begin
        ls_pin0_drv.in  = 1'b0;
        ls_pin1_drv.in  = 1'b0;
        ls_pin0_drv.out = ls_on ? 1'b0 : gpio_out[0];
        ls_pin0_drv.oe  = ls_on ? 1'b0 : gpio_oe[0];
        ls_pin1_drv.out = ls_on ? 1'b0 : gpio_out[1];
        ls_pin1_drv.oe  = ls_on ? 1'b0 : gpio_oe[1];
    end

    assign hs_osc_on                 = hs_on;
    assign ls_osc_on                 = ls_on;
    assign selected_oscillator_input = osc_q;
    assign core_tick                 = core_q;
    assign instr_tick                = instr_q;
    assign sel_low                   = run_low;
    assign switch_busy               = (state_q == dcd_pkg::DCD_WAIT_LOW) || (state_q == dcd_pkg::DCD_WAIT_HIGH);
    assign hs_overspeed              = ovr_q;
    assign gpio_in                   = gpio_in_q;

endmodule

// ==== logic/dcd_defines.svh ====
// Timing and reset constants for the dual oscillator clock doubler
`ifndef DCD_DEFINES_SVH
`define DCD_DEFINES_SVH

`define DCD_MCLK_PERIOD_PS     4000
`define DCD_HS_MAX_FREQ_KHZ    10000
`define DCD_LS_NOM_FREQ_HZ     32768
// Shortest legal high speed half period in ps, 50000 ps at 10 MHz
`define DCD_HS_MIN_HALF_PS     (500000000 / `DCD_HS_MAX_FREQ_KHZ)
// Least time rounds up to whole cycles
`define DCD_HS_MIN_HALF_CYC    ((`DCD_HS_MIN_HALF_PS + `DCD_MCLK_PERIOD_PS - 1) / `DCD_MCLK_PERIOD_PS)
`define DCD_CORE_PER_INSTR     10
`define DCD_RESET_SEL_LOW      1'b0

`endif

// ==== logic/dcd_pkg.sv ====
// Types for the dual oscillator clock doubler
package dcd_pkg;

    typedef enum logic [1:0] {
        DCD_RUN_HIGH,
        DCD_WAIT_LOW,
        DCD_RUN_LOW,
        DCD_WAIT_HIGH
    } dcd_state_type;

    typedef struct packed {
        logic in;
        logic out;
        logic oe;
    } dcd_pin_type;

endpackage

// ==== testbench/dcd_clock_doubler_chk.sv ====
// Assertions for the dual oscillator clock doubler
`timescale 1ns/1ps
module dcd_clock_doubler_chk #(
    parameter int unsigned CORE_PER_INSTR = 10
) (
    // Clock and reset
    input wire logic                 mclk,
    input wire logic                 rst_n,
    // Watched ports
    input wire logic                 sel_low_req,
    input wire logic [1:0]           gpio_out,
    input wire logic [1:0]           gpio_oe,
    input wire dcd_pkg::dcd_pin_type ls_pin0_drv,
    input wire dcd_pkg::dcd_pin_type ls_pin1_drv,
    input wire logic                 hs_osc_on,
    input wire logic                 ls_osc_on,
    input wire logic                 selected_oscillator_input,
    input wire logic                 core_tick,
    input wire logic                 instr_tick,
    input wire logic                 sel_low,
    input wire logic                 switch_busy,
    input wire logic                 hs_overspeed
);
    int unsigned cnt_q;
    int unsigned cnt_d;
    always_comb begin
        cnt_d = cnt_q;
        if (core_tick) cnt_d = (cnt_q == CORE_PER_INSTR - 1) ? 0 : cnt_q + 1;
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) cnt_q <= 0;
        else cnt_q <= cnt_d;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_enter; !switch_busy ##1 switch_busy; endsequence
    property p_tick; !switch_busy && $changed(selected_oscillator_input) |-> core_tick; endproperty
    property p_instr; instr_tick |-> core_tick; endproperty
    property p_div; core_tick |-> instr_tick == (cnt_q == CORE_PER_INSTR - 1); endproperty
    property p_enter; s_enter |-> $past(sel_low_req) != sel_low; endproperty
    property p_busy_on; switch_busy |-> hs_osc_on && ls_osc_on; endproperty
    property p_sel_on; !switch_busy |-> (sel_low ? ls_osc_on : hs_osc_on); endproperty
    property p_gpio; !ls_osc_on |-> ls_pin0_drv.out == gpio_out[0] && ls_pin1_drv.oe == gpio_oe[1]
        && ls_pin0_drv.oe == gpio_oe[0] && ls_pin1_drv.out == gpio_out[1]; endproperty
    property p_ovr_hold; hs_overspeed |=> hs_overspeed; endproperty
    property p_release; ls_osc_on |-> !ls_pin0_drv.oe && !ls_pin1_drv.oe; endproperty
    property p_gap; core_tick |=> !core_tick; endproperty
    a_tick: assert property (p_tick) else $error("core tick missing on oscillator edge");
    a_instr: assert property (p_instr) else $error("instruction tick without core tick");
    a_div: assert property (p_div) else $error("instruction tick not on tenth core tick");
    a_enter: assert property (p_enter) else $error("handover started without request");
    a_busy_on: assert property (p_busy_on) else $error("handover with oscillator off");
    a_sel_on: assert property (p_sel_on) else $error("selected oscillator turned off");
    a_gpio: assert property (p_gpio) else $error("port drive not passed to pins");
    a_release: assert property (p_release) else $error("pins driven in oscillator use");
    a_gap: assert property (p_gap) else $error("core tick longer than one cycle");
    a_ovr_hold: assert property (p_ovr_hold) else $error("overspeed flag cleared without reset");
endmodule
bind dcd_clock_doubler dcd_clock_doubler_chk #(.CORE_PER_INSTR(CORE_PER_INSTR)) chk_u (.mclk, .rst_n,
    .sel_low_req, .gpio_out, .gpio_oe, .ls_pin0_drv, .ls_pin1_drv, .hs_osc_on, .ls_osc_on,
    .selected_oscillator_input, .core_tick, .instr_tick, .sel_low, .switch_busy, .hs_overspeed);

// ==== testbench/dcd_clock_doubler_tb.sv ====
// Bench for the dual oscillator clock doubler
`timescale 1ns/1ps
module dcd_clock_doubler_tb;
    logic                 mclk = 1'b0;
    logic                 rst_n, hs, slr, hse, lse, sin, ct, it, sl, busy, hon, lon, ovs;
    logic [1:0]           go, goe, gin;
    dcd_pkg::dcd_pin_type p0, p1, d0, d1;
    int                   error_cnt, samples_checked, nc, ni;
    dcd_clock_doubler dut_u (.mclk(mclk), .rst_n(rst_n), .hs_osc_pin(hs), .ls_pin0(p0), .ls_pin0_drv(d0),
        .ls_pin1(p1), .ls_pin1_drv(d1), .sel_low_req(slr), .hs_enable_req(hse), .ls_enable_req(lse),
        .gpio_out(go), .gpio_oe(goe), .gpio_in(gin), .hs_osc_on(hon), .ls_osc_on(lon),
        .selected_oscillator_input(sin), .core_tick(ct), .instr_tick(it), .sel_low(sl),
        .switch_busy(busy), .hs_overspeed(ovs));
    always #2 mclk = ~mclk;
    always @(posedge mclk) begin
        if (ct === 1'b1) nc++;
        if (it === 1'b1) ni++;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Edges spaced 20 cycles, slower than the fastest legal primary rate
    task automatic tog(input bit low, input int n);
        repeat (n) begin
            if (low) p0.in = ~p0.in;
            else hs = ~hs;
            cyc(20);
        end
    endtask
    task automatic end_sim;
        $display("Checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic t_double;
        tog(0, 20);
        chk(nc, 20);
        chk(ni, 2);
        chk(ovs, 0);
    endtask
    task automatic t_to_low;
        lse = 1'b1;
        slr = 1'b1;
        cyc(1);
        chk({busy, sl}, 8'h02);
        tog(1, 1);
        chk({busy, sl}, 8'h01);
        chk(nc, 21);
        chk(sin, 1);
        hse = 1'b0;
        cyc(1);
        chk(hon, 0);
        tog(1, 10);
        chk(nc, 31);
        chk(ni, 3);
    endtask
    task automatic t_refuse;
        slr = 1'b0;
        cyc(2);
        chk({busy, sl}, 8'h01);
        tog(0, 2);
        chk(nc, 31);
        hse = 1'b1;
        cyc(1);
        chk(busy, 1);
        tog(0, 1);
        chk(sl, 0);
        chk(nc, 32);
        chk(sin, 1);
        lse = 1'b0;
        cyc(1);
        chk(lon, 0);
    endtask
    task automatic t_gpio;
        go = 2'b01;
        goe = 2'b11;
        p1.in = 1'b1;
        cyc(1);
        chk({d1.out, d1.oe, d0.out, d0.oe}, 8'h07);
        cyc(4);
        chk(gin, 2'b11);
        lse = 1'b1;
        cyc(1);
        chk({d1.oe, d0.oe}, 8'h00);
        chk(gin, 2'b00);
    endtask
    // Dropped request, fast primary edges, then a reset in mid-run
    task automatic t_recover;
        int n0;
        slr = 1'b1;
        cyc(1);
        chk(busy, 1);
        slr = 1'b0;
        cyc(1);
        chk({busy, sl}, 8'h00);
        chk(ovs, 0);
        // Edges five cycles apart, faster than the primary limit
        repeat (3) begin
            hs = ~hs;
            cyc(5);
        end
        cyc(8);
        chk(ovs, 1);
        rst_n = 1'b0;
        cyc(1);
        rst_n = 1'b1;
        cyc(6);
        chk(ovs, 0);
        chk({busy, sl}, 8'h00);
        chk(hon, 1);
        chk(sin, 0);
        n0 = nc;
        hs = ~hs;
        cyc(8);
        chk(sin, 1);
        chk(nc, n0 + 1);
    endtask
    initial begin
        {error_cnt, samples_checked, nc, ni} = '0;
        {rst_n, hs, slr, lse, go, goe} = '0;
        hse = 1'b1;
        p0 = '0;
        p1 = '0;
        cyc(2);
        rst_n = 1'b1;
        cyc(1);
        t_double();
        t_to_low();
        t_refuse();
        t_gpio();
        t_recover();
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        end_sim();
    end
endmodule
